// [design/dac_latch_consts.svh]
// Constants for the double-buffered reference code bank
`ifndef DAC_LATCH_CONSTS_SVH
`define DAC_LATCH_CONSTS_SVH

`define NUM_CHAN    20
`define CODE_W      10
`define CH_W        5
`define WORD_W      16
`define MID_CODE    10'h200
`define LAST_CHAN   5'h13
`define FIRST_VCOM  5'h12
`define CHAN_MSBS   3'h0
`define BULK_BIT    15
`define DEV_ADDR    7'h4C // Arbitrary bus address
`define GC_ADDR     8'h00
`define GC_RESET    8'h06
`define BYTE_BITS   4'h8

`endif

// [design/dac_latch_pkg.sv]
// Types shared by the reference code bank
package dac_latch_pkg;
  `include "dac_latch_consts.svh"

  typedef logic [`NUM_CHAN-1:0][`CODE_W-1:0] chan_bank_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_DEV  = 3'b001,
    RX_CHAN = 3'b010,
    RX_MSB  = 3'b011,
    RX_LSB  = 3'b100,
    RX_GCMD = 3'b101,
    RX_SKIP = 3'b110
  } rx_state_t;
endpackage

// [design/evt_sync_if.sv]
// Toggle event carried from the link domain to the core domain
`timescale 1ns/1ps
`default_nettype none
interface evt_sync_if;
  logic tgl;
  logic pulse;
  modport sync (input tgl, output pulse);
  modport user (output tgl, input pulse);
endinterface
`default_nettype wire

// [design/evt_sync.sv]
// Toggle synchroniser turning a link-domain toggle into a core pulse
`timescale 1ns/1ps
`default_nettype none
module evt_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  evt_sync_if.sync  evt
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= evt.tgl;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign evt.pulse = s2_ff ^ s3_ff;
endmodule
`default_nettype wire

// [design/dac_double_buffer_latch.sv]
// Two-wire word receiver and double-buffered latch for twenty reference codes
`timescale 1ns/1ps
`default_nettype none
`include "dac_latch_consts.svh"
module dac_double_buffer_latch
  import dac_latch_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  wire logic     link_clk,
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  input  wire logic     output_load_pin,
  output logic          sda_out,
  output logic          sda_oe_n,
  output var chan_bank_t dac_code
);

  // ==========================================================
  // Decode helpers
  function automatic logic chan_valid(input logic [7:0] b);
    chan_valid = (b[7:5] == `CHAN_MSBS) && (b[4:0] <= `LAST_CHAN);
  endfunction

  // ==========================================================
  // Link domain synchronisers
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_s3_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= rst_n;
    lrst_s2_ff <= lrst_s1_ff;
    scl_s1_ff  <= scl_in;
    scl_s2_ff  <= scl_s1_ff;
    scl_s3_ff  <= scl_s2_ff;
    sda_s1_ff  <= sda_in;
    sda_s2_ff  <= sda_s1_ff;
    sda_s3_ff  <= sda_s2_ff;
  end

  wire scl_rise = scl_s2_ff & ~scl_s3_ff;
  wire scl_fall = ~scl_s2_ff & scl_s3_ff;
  wire scl_high = scl_s2_ff & scl_s3_ff;
  wire bus_start = scl_high & ~sda_s2_ff & sda_s3_ff;
  wire bus_stop  = scl_high & sda_s2_ff & ~sda_s3_ff;

  // ==========================================================
  // Link domain receiver
  rx_state_t          st_ff;
  rx_state_t          nxt_st;
  logic [3:0]         bit_cnt_ff;
  logic [7:0]         shift_ff;
  logic               in_ack_ff;
  logic               ack_drv_ff;
  logic [`CH_W-1:0]   ch_ff;
  logic [7:0]         msb_ff;
  logic [`WORD_W-1:0] wr_data_ff;
  logic [`CH_W-1:0]   wr_ch_ff;
  logic               wr_tgl_ff;
  logic               gc_tgl_ff;
  logic               nxt_ack;
  logic               emit_word;
  logic               emit_gc;

  wire byte_done = scl_fall & ~in_ack_ff & (bit_cnt_ff == `BYTE_BITS);

  always_comb begin
    nxt_st    = st_ff;
    nxt_ack   = 1'b0;
    emit_word = 1'b0;
    emit_gc   = 1'b0;
    unique case (st_ff)
      RX_IDLE, RX_SKIP: begin
        nxt_st = st_ff;
      end
      RX_DEV: begin
        if (shift_ff == {`DEV_ADDR, 1'b0}) begin
          nxt_st  = RX_CHAN;
          nxt_ack = 1'b1;
        end else if (shift_ff == `GC_ADDR) begin
          nxt_st  = RX_GCMD;
          nxt_ack = 1'b1;
        end else begin
          nxt_st = RX_SKIP;
        end
      end
      RX_CHAN: begin
        nxt_ack = chan_valid(shift_ff);
        nxt_st  = chan_valid(shift_ff) ? RX_MSB : RX_SKIP;
      end
      RX_MSB: begin
        nxt_ack = 1'b1;
        nxt_st  = RX_LSB;
      end
      RX_LSB: begin
        nxt_ack   = 1'b1;
        emit_word = 1'b1;
        nxt_st    = (ch_ff == `LAST_CHAN) ? RX_SKIP : RX_MSB;
      end
      RX_GCMD: begin
        nxt_ack = (shift_ff == `GC_RESET);
        emit_gc = (shift_ff == `GC_RESET);
        nxt_st  = RX_SKIP;
      end
      default: begin
        nxt_st = RX_SKIP;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_ff) begin
      st_ff      <= RX_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      in_ack_ff  <= 1'b0;
      ack_drv_ff <= 1'b0;
      ch_ff      <= 5'h00;
      msb_ff     <= 8'h00;
      wr_data_ff <= 16'h0000;
      wr_ch_ff   <= 5'h00;
      wr_tgl_ff  <= 1'b0;
      gc_tgl_ff  <= 1'b0;
    end else if (bus_start || bus_stop) begin
      st_ff      <= bus_start ? RX_DEV : RX_IDLE;
      bit_cnt_ff <= 4'h0;
      in_ack_ff  <= 1'b0;
      ack_drv_ff <= 1'b0;
    end else begin
      if (scl_rise && !in_ack_ff && bit_cnt_ff != `BYTE_BITS) begin
        shift_ff   <= {shift_ff[6:0], sda_s2_ff};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (scl_fall && in_ack_ff) begin
        in_ack_ff  <= 1'b0;
        ack_drv_ff <= 1'b0;
        bit_cnt_ff <= 4'h0;
      end else if (byte_done) begin
        in_ack_ff  <= 1'b1;
        ack_drv_ff <= nxt_ack;
        st_ff      <= nxt_st;
        if (st_ff == RX_CHAN) begin
          ch_ff <= shift_ff[4:0];
        end
        if (st_ff == RX_MSB) begin
          msb_ff <= shift_ff;
        end
        if (emit_word) begin
          wr_data_ff <= {msb_ff, shift_ff};
          wr_ch_ff   <= ch_ff;
          wr_tgl_ff  <= ~wr_tgl_ff;
          ch_ff      <= ch_ff + 5'h01;
        end
        if (emit_gc) begin
          gc_tgl_ff <= ~gc_tgl_ff;
        end
      end
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~ack_drv_ff;

  // ==========================================================
  // Crossing into the core domain
  evt_sync_if wr_if ();
  evt_sync_if gc_if ();

  assign wr_if.tgl = wr_tgl_ff;
  assign gc_if.tgl = gc_tgl_ff;

  evt_sync u_wr_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .evt   (wr_if)
  );

  evt_sync u_gc_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .evt   (gc_if)
  );

  logic load_s1_ff;
  logic load_s2_ff;

  always_ff @(posedge mclk) begin
    load_s1_ff <= output_load_pin;
    load_s2_ff <= load_s1_ff;
  end

  // ==========================================================
  // Double-buffered code bank
  chan_bank_t in_ff;
  chan_bank_t nxt_in;
  chan_bank_t nxt_lat;

  wire wr_evt  = wr_if.pulse;
  wire gc_evt  = gc_if.pulse;
  wire load_hi = load_s2_ff;
  wire bulk    = wr_evt & wr_data_ff[`BULK_BIT];
  wire copy    = gc_evt | ~load_hi | bulk;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHAN; gi++) begin : g_chan
      wire hit = wr_evt & (wr_ch_ff == `CH_W'(gi));
      assign nxt_in[gi] = gc_evt ? `MID_CODE :
                          hit    ? wr_data_ff[`CODE_W-1:0] : in_ff[gi];
    end
  endgenerate

  assign nxt_lat = copy ? nxt_in : dac_code;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_ff    <= {`NUM_CHAN{`MID_CODE}};
      dac_code <= {`NUM_CHAN{`MID_CODE}};
    end else begin
      in_ff    <= nxt_in;
      dac_code <= nxt_lat;
    end
  end

  // ==========================================================
  // Assertions
  logic [`CH_W-1:0] ch_q_ff;

  always_ff @(posedge mclk) begin
    ch_q_ff <= wr_ch_ff;
  end

  latch_hold_a : assert property (@(posedge mclk) disable iff (!rst_n)
    load_hi && !wr_evt && !gc_evt |=> $stable(dac_code))
    else $error("latch moved without a trigger");

  input_store_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_evt && !gc_evt |=> in_ff[ch_q_ff] == $past(wr_data_ff[`CODE_W-1:0]))
    else $error("input register missed a write");

  bulk_copy_a : assert property (@(posedge mclk) disable iff (!rst_n)
    load_hi && bulk |=> dac_code == in_ff)
    else $error("bulk transfer incomplete");

  latch_cause_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(dac_code) && $past(load_hi) |-> $past(wr_evt || gc_evt))
    else $error("latch changed without a finished word");

  reset_mid_a : assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> dac_code == {`NUM_CHAN{`MID_CODE}} && in_ff == dac_code)
    else $error("reset did not give mid-span");

  vcom_alone_a : assert property (@(posedge mclk) disable iff (!rst_n)
    wr_evt && !gc_evt && wr_ch_ff >= `FIRST_VCOM |=> in_ff[17:0] == $past(in_ff[17:0]))
    else $error("common-voltage write touched gamma");

  follow_low_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !load_hi ##1 !load_hi |-> dac_code == in_ff)
    else $error("latch not following input with pin low");

  gc_reload_a : assert property (@(posedge mclk) disable iff (!rst_n)
    gc_evt |=> dac_code == {`NUM_CHAN{`MID_CODE}})
    else $error("general call did not reload latches");

  low_bulk_a : assert property (@(posedge mclk) disable iff (!rst_n)
    !load_hi && bulk && !gc_evt |=> dac_code[ch_q_ff] == $past(wr_data_ff[`CODE_W-1:0]))
    else $error("bit-15 write with pin low misbehaved");

  chan_range_a : assert property (@(posedge link_clk) disable iff (!lrst_s2_ff)
    $changed(wr_tgl_ff) |-> chan_valid({3'h0, wr_ch_ff}))
    else $error("word written to invalid channel");

  word_after_lsb_a : assert property (@(posedge link_clk) disable iff (!lrst_s2_ff)
    $changed(wr_tgl_ff) |-> $past(st_ff) == RX_LSB && $past(byte_done))
    else $error("word emitted before both bytes");

  bulk_cov : cover property (@(posedge mclk) disable iff (!rst_n) load_hi && bulk);
  gc_cov   : cover property (@(posedge mclk) disable iff (!rst_n) gc_evt);
  low_cov  : cover property (@(posedge mclk) disable iff (!rst_n) !load_hi && wr_evt);
  vcom_cov : cover property (@(posedge mclk) disable iff (!rst_n) wr_evt && wr_ch_ff == `LAST_CHAN);

endmodule
`default_nettype wire

// [bench/two_wire_host.sv]
// Two-wire bus host model for the reference code bank
`timescale 1ns/1ps
`default_nettype none
module two_wire_host (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_drv
);
  int half_cyc = 1;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ====================
  // Bus phases, released sda reads the pull-up
  task automatic half();
    repeat (half_cyc) @(posedge mclk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
      half();
    end
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    ack = !sda;
    scl <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// [bench/dac_double_buffer_latch_tb.sv]
// Self-checking bench for the double-buffered reference code bank
`timescale 1ns/1ps
`default_nettype none
`include "dac_latch_consts.svh"
module dac_double_buffer_latch_tb
  import dac_latch_pkg::*;
;
  localparam int BW = $bits(chan_bank_t);
  logic       mclk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       pin = 1'b1;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe_n;
  chan_bank_t dac_code;
  chan_bank_t exp_in;
  chan_bank_t exp_out;
  chan_bank_t prev;
  chan_bank_t notes[$];
  int         n_errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  logic       mon_on = 1'b0;
  wire        sda = sda_drv & (sda_oe_n | sda_out);

  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  dac_double_buffer_latch u_dac_double_buffer_latch (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .link_clk        (link_clk),
    .scl_in          (scl),
    .sda_in          (sda),
    .output_load_pin (pin),
    .sda_out         (sda_out),
    .sda_oe_n        (sda_oe_n),
    .dac_code        (dac_code)
  );
  two_wire_host u_two_wire_host (
    .mclk    (mclk),
    .sda     (sda),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  // ====================
  // Checking and closing
  task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic out_set(input chan_bank_t nb);
    if (nb !== exp_out) begin
      exp_out = nb;
      notes.push_back(nb);
    end
  endtask
  always @(negedge mclk) begin
    if (mon_on && dac_code !== prev) begin
      if (notes.size() == 0) check(dac_code, prev);
      else check(dac_code, notes.pop_front());
      prev = dac_code;
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ====================
  // Bus transfers
  task automatic xfer(input logic [7:0] b, input logic want);
    logic ack;
    u_two_wire_host.put_byte(b, ack);
    check(BW'(ack), BW'(want));
  endtask
  task automatic wr(input logic [4:0] ch, input int n, input logic bulk);
    logic [9:0] code;
    u_two_wire_host.start();
    xfer({`DEV_ADDR, 1'b0}, 1'b1);
    xfer({3'h0, ch}, 1'b1);
    for (int k = 0; k < n; k++) begin
      code = 10'($urandom);
      if (code === exp_out[ch]) code = ~code;
      xfer({bulk && k == n - 1, 5'h00, code[9:8]}, 1'b1);
      exp_in[ch] = code;
      if (!pin || (bulk && k == n - 1)) out_set(exp_in);
      xfer(code[7:0], 1'b1);
      ch++;
    end
    u_two_wire_host.stop();
  endtask

  // ====================
  // Main sequence
  initial begin
    void'($urandom(58));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check(dac_code, {`NUM_CHAN{`MID_CODE}});
    exp_in = {`NUM_CHAN{`MID_CODE}};
    exp_out = exp_in;
    prev = dac_code;
    mon_on = 1'b1;
    wr(5'h00, 18, 1'b1);
    wr(5'h12, 1, 1'b0);
    wr(5'h13, 1, 1'b1);
    u_two_wire_host.start();
    xfer({`DEV_ADDR, 1'b0}, 1'b1);
    xfer(8'h05, 1'b1);
    xfer(8'h01, 1'b1);
    u_two_wire_host.stop();
    u_two_wire_host.half_cyc = 2;
    wr(5'h00, 1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_two_wire_host.start();
      xfer({`DEV_ADDR, i == 2}, i != 2);
      if (i < 2) xfer(i ? 8'h20 : 8'h14, 1'b0);
    end
    u_two_wire_host.stop();
    pin <= 1'b0;
    wr(5'h13, 1, 1'b1);
    wr(5'h03, 2, 1'b0);
    pin <= 1'b1;
    wr(5'h07, 1, 1'b0);
    u_two_wire_host.start();
    xfer({~`DEV_ADDR, 1'b0}, 1'b0);
    u_two_wire_host.start();
    xfer(`GC_ADDR, 1'b1);
    xfer(8'h04, 1'b0);
    u_two_wire_host.start();
    xfer({`DEV_ADDR, 1'b0}, 1'b1);
    xfer(8'h05, 1'b1);
    xfer(8'h02, 1'b1);
    u_two_wire_host.start();
    xfer({`DEV_ADDR, 1'b0}, 1'b1);
    xfer({3'h0, `LAST_CHAN}, 1'b1);
    xfer(8'h01, 1'b1);
    xfer(8'h55, 1'b1);
    exp_in[`LAST_CHAN] = 10'h155;
    xfer(8'h00, 1'b0);
    u_two_wire_host.stop();
    @(posedge mclk);
    pin <= 1'b0;
    out_set(exp_in);
    repeat (10) @(posedge mclk);
    pin <= 1'b1;
    u_two_wire_host.start();
    xfer(`GC_ADDR, 1'b1);
    exp_in = {`NUM_CHAN{`MID_CODE}};
    out_set(exp_in);
    xfer(`GC_RESET, 1'b1);
    u_two_wire_host.stop();
    wr(5'h00, 1, 1'b1);
    repeat (20) @(posedge mclk);
    check(BW'(notes.size()), '0);
    wrap_up();
  end
endmodule
`default_nettype wire
